// ---- inc/sdram_pkg.sv ----
// Shared constants, types and helpers of the SDRAM command core
package sdram_pkg;
	// --------------------------------------------------------------
	// Geometry
	// --------------------------------------------------------------
	localparam int COL_W = 9;
	localparam int ROW_W = 12;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int DATA_W = 16;
	localparam int AP_BIT = 10;
	localparam int CNT_W = 8;
	localparam int PIPE_D = 2;
	// --------------------------------------------------------------
	// Command codes as {cs_n, ras_n, cas_n, we_n}
	// --------------------------------------------------------------
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// --------------------------------------------------------------
	// Mode register layout
	// --------------------------------------------------------------
	localparam int MODE_W = 6;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam logic [MODE_W-1:0] MODE_RST = 6'h33;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int T_RP_NS = 20;
	localparam int T_WR_NS = 10;
	localparam int T_RC_NS = 70;
	localparam int T_SREX_NS = 10;
	localparam logic [CNT_W-1:0] TRP_CYC =
		CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] WR_CYC =
		CNT_W'((T_WR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] SREX_CYC =
		CNT_W'((T_RC_NS + T_SREX_NS + CLK_NS - 1) / CLK_NS);
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_PDOWN = 4'h2,
		ST_SELF = 4'h4,
		ST_EXIT = 4'h8
	} pwr_t;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_t;
	typedef struct packed {
		logic we;
		logic re;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DATA_W-1:0] wdata;
	} arr_req_t;
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
		case (bl)
			3'h0: burst_mask = 9'h000;
			3'h1: burst_mask = 9'h001;
			3'h2: burst_mask = 9'h003;
			3'h3: burst_mask = 9'h007;
			3'h7: burst_mask = 9'h1ff;
			default: burst_mask = 9'h000;
		endcase
	endfunction : burst_mask
	function automatic logic [NBANK-1:0] bank_bit(
		input logic [BANK_W-1:0] b);
		bank_bit = NBANK'(1) << b;
	endfunction : bank_bit
endpackage : sdram_pkg

// ---- src/col_gen.sv ----
// Burst column address generator, sequential or interleaved order
`timescale 1ns/1ps
module col_gen #(
	parameter int COL_W = sdram_pkg::COL_W
) (
	input logic [COL_W-1:0] start,
	input logic [COL_W-1:0] beat,
	input logic [COL_W-1:0] mask,
	input logic ilv,
	output logic [COL_W-1:0] col
);
	import sdram_pkg::*;
	wire [COL_W-1:0] seq_low = start + beat;
	wire [COL_W-1:0] ilv_low = start ^ beat;
	wire [COL_W-1:0] low = ilv ? ilv_low : seq_low;
	// Upper bits fixed, no carry out of the burst window
	assign col = (start & ~mask) | (low & mask);
endmodule : col_gen

// ---- src/read_pipe.sv ----
// Read data delay line with selectable tap for CAS latency
`timescale 1ns/1ps
module read_pipe #(
	parameter int DW = sdram_pkg::DATA_W,
	parameter int DEPTH = sdram_pkg::PIPE_D
) (
	input logic clk,
	input logic resetn,
	input logic push_v,
	input logic [DW-1:0] push_d,
	input logic sel,
	output logic out_v,
	output logic [DW-1:0] out_d
);
	import sdram_pkg::*;
	logic [DEPTH-1:0] v_r;
	logic [DW-1:0] d_r [DEPTH];
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			v_r <= '0;
			for (int i = 0; i < DEPTH; i++)
				d_r[i] <= '0;
		end
		else
		begin
			v_r <= {v_r[DEPTH-2:0], push_v};
			d_r[0] <= push_d;
			for (int i = 1; i < DEPTH; i++)
				d_r[i] <= d_r[i-1];
		end
	end
	assign out_v = v_r[sel];
	assign out_d = d_r[sel];
endmodule : read_pipe

// ---- src/sdram_cmd_core.sv ----
// SDRAM command core: bursts, precharge, power modes
// Notes on behaviour
// - A write during a write burst restarts at the new column.
// - A read cuts a write burst at once; leftover write data dropped.
// - Burst stop code: cs_n and we_n low, ras_n and cas_n high.
// - After burst stop: read output idles after CAS latency; writes stop.
// - Sequential order increments and wraps inside the burst window.
// - Interleaved order flips low column bits from the start column.
// - Address bit 10 high on read or write selects auto-precharge, except in full page.
// - Read auto-precharge starts CAS latency before the burst ends.
// - Write auto-precharge starts one clock after last beat.
// - Precharge code; bit 10 picks all banks, else bank address.
// - Self refresh entry with cke low and all banks idle.
// - Self refresh ignores commands; exit waits row cycle plus exit.
// - cke low with no burst enters power-down.
// - No-operation and deselect leave a running burst untouched.
// - Read code: cs_n and cas_n low, ras_n and we_n high.
`timescale 1ns/1ps
module sdram_cmd_core (
	input logic clk,
	input logic resetn,
	input logic cke,
	input sdram_pkg::cmd_t cmd,
	input logic [sdram_pkg::BANK_W-1:0] ba,
	input logic [sdram_pkg::ADDR_W-1:0] addr,
	input logic dqm,
	input logic [sdram_pkg::DATA_W-1:0] dq_i,
	output logic [sdram_pkg::DATA_W-1:0] dq_o,
	output logic dq_oe,
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata,
	output sdram_pkg::arr_req_t arr_req,
	input logic [sdram_pkg::DATA_W-1:0] arr_rdata
);
	import sdram_pkg::*;
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [MODE_W-1:0] mode_r;
	pwr_t pwr_r;
	pwr_t pwr_nxt;
	logic [CNT_W-1:0] pwr_cnt_r;
	logic [NBANK-1:0] open_r;
	logic [ROW_W-1:0] row_r [NBANK];
	logic [CNT_W-1:0] rec_r [NBANK];
	logic [NBANK-1:0] busy;
	logic act_r;
	logic wr_r;
	logic ap_r;
	logic [BANK_W-1:0] bank_r;
	logic [COL_W-1:0] start_r;
	logic [COL_W-1:0] beat_r;
	logic [CNT_W-1:0] wap_cnt_r;
	logic [BANK_W-1:0] wap_bank_r;
	logic [1:0] dqm_d_r;
	logic pipe_v;
	arr_req_t req_nxt;
	// --------------------------------------------------------------
	// Mode fields
	// --------------------------------------------------------------
	wire [2:0] bl = mode_r[MODE_BL_LSB +: 3];
	wire ilv = mode_r[MODE_BT_BIT];
	wire [1:0] cl = mode_r[MODE_CL_LSB +: 2];
	wire [COL_W-1:0] mask = burst_mask(bl);
	wire full = (bl == BL_FULL);
	// --------------------------------------------------------------
	// Command decode
	// --------------------------------------------------------------
	wire [3:0] code = cmd;
	wire run = (pwr_r == ST_RUN);
	wire take = run & cke;
	wire c_rd = take & (code == CMD_RD) & open_r[ba];
	wire c_wr = take & (code == CMD_WR) & open_r[ba];
	wire c_bst = take & (code == CMD_BST);
	wire c_pre = take & (code == CMD_PRE);
	wire c_act = take & (code == CMD_ACT) & !open_r[ba] & !busy[ba];
	wire all_idle = (open_r == '0) & !act_r & (wap_cnt_r == '0);
	wire c_self = run & !cke & (code == CMD_REF) & all_idle;
	wire [NBANK-1:0] pre_mask =
		addr[AP_BIT] ? {NBANK{1'b1}} : bank_bit(ba);
	// --------------------------------------------------------------
	// Burst sequencing
	// --------------------------------------------------------------
	wire pre_hit = c_pre & pre_mask[bank_r];
	wire nb = c_rd | c_wr;
	wire go = nb | (act_r & !c_bst & !pre_hit);
	wire [COL_W-1:0] cur_start = nb ? addr[COL_W-1:0] : start_r;
	wire [COL_W-1:0] cur_beat = nb ? '0 : beat_r;
	wire [BANK_W-1:0] cur_bank = nb ? ba : bank_r;
	wire cur_wr = nb ? c_wr : wr_r;
	wire cur_ap = nb ? (addr[AP_BIT] & !full) : ap_r;
	wire last = go & !full & (cur_beat == mask);
	wire [COL_W-1:0] cur_col;
	col_gen #(.COL_W(COL_W)) u_col (
		.start(cur_start),
		.beat(cur_beat),
		.mask(mask),
		.ilv(ilv),
		.col(cur_col)
	);
	// --------------------------------------------------------------
	// Precharge sources
	// --------------------------------------------------------------
	wire rd_ap_go = last & !cur_wr & cur_ap;
	wire wr_ap_go = (wap_cnt_r == CNT_W'(1));
	wire [NBANK-1:0] close =
		(c_pre ? pre_mask : '0) |
		(rd_ap_go ? bank_bit(cur_bank) : '0) |
		(wr_ap_go ? bank_bit(wap_bank_r) : '0);
	// --------------------------------------------------------------
	// Array request
	// --------------------------------------------------------------
	always_comb
	begin
		req_nxt.we = go & cur_wr & !dqm;
		req_nxt.re = go & !cur_wr;
		req_nxt.bank = cur_bank;
		req_nxt.row = row_r[cur_bank];
		req_nxt.col = cur_col;
		req_nxt.wdata = dq_i;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			arr_req <= '0;
		else
			arr_req <= req_nxt;
	end
	// --------------------------------------------------------------
	// Burst registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			act_r <= 1'b0;
			wr_r <= 1'b0;
			ap_r <= 1'b0;
			bank_r <= '0;
			start_r <= '0;
			beat_r <= '0;
		end
		else
		begin
			act_r <= go & !last;
			wr_r <= go & cur_wr;
			ap_r <= cur_ap;
			bank_r <= cur_bank;
			start_r <= cur_start;
			beat_r <= cur_beat + COL_W'(1);
		end
	end
	// --------------------------------------------------------------
	// Bank state and recovery
	// --------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NBANK; i++)
			busy[i] = (rec_r[i] != '0);
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			open_r <= '0;
			wap_cnt_r <= '0;
			wap_bank_r <= '0;
			for (int i = 0; i < NBANK; i++)
			begin
				rec_r[i] <= '0;
				row_r[i] <= '0;
			end
		end
		else
		begin
			if (last & cur_wr & cur_ap)
			begin
				wap_cnt_r <= WR_CYC;
				wap_bank_r <= cur_bank;
			end
			else if (wap_cnt_r != '0)
				wap_cnt_r <= wap_cnt_r - CNT_W'(1);
			for (int i = 0; i < NBANK; i++)
			begin
				if (close[i])
				begin
					open_r[i] <= 1'b0;
					rec_r[i] <= TRP_CYC;
				end
				else
				begin
					if (busy[i])
						rec_r[i] <= rec_r[i] - CNT_W'(1);
					if (c_act && ba == BANK_W'(i))
					begin
						open_r[i] <= 1'b1;
						row_r[i] <= addr;
					end
				end
			end
		end
	end
	// --------------------------------------------------------------
	// Power modes
	// --------------------------------------------------------------
	always_comb
	begin
		case (pwr_r)
			ST_RUN:
				if (c_self)
					pwr_nxt = ST_SELF;
				else if (!cke && !act_r && wap_cnt_r == '0)
					pwr_nxt = ST_PDOWN;
				else
					pwr_nxt = ST_RUN;
			ST_PDOWN:
				pwr_nxt = cke ? ST_RUN : ST_PDOWN;
			ST_SELF:
				pwr_nxt = cke ? ST_EXIT : ST_SELF;
			ST_EXIT:
				pwr_nxt = (pwr_cnt_r == CNT_W'(1)) ? ST_RUN : ST_EXIT;
			default:
				pwr_nxt = ST_RUN;
		endcase
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pwr_r <= ST_RUN;
			pwr_cnt_r <= '0;
		end
		else
		begin
			pwr_r <= pwr_nxt;
			if (pwr_r == ST_SELF && cke)
				pwr_cnt_r <= SREX_CYC;
			else if (pwr_cnt_r != '0)
				pwr_cnt_r <= pwr_cnt_r - CNT_W'(1);
		end
	end
	// --------------------------------------------------------------
	// Read data path
	// --------------------------------------------------------------
	read_pipe #(.DW(DATA_W), .DEPTH(PIPE_D)) u_pipe (
		.clk(clk),
		.resetn(resetn),
		.push_v(arr_req.re),
		.push_d(arr_rdata),
		.sel(cl[0]),
		.out_v(pipe_v),
		.out_d(dq_o)
	);
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			dqm_d_r <= 2'h3;
		else
			dqm_d_r <= {dqm_d_r[0], dqm};
	end
	// Output mask lags dqm by two clocks
	assign dq_oe = pipe_v & !dqm_d_r[1];
	// --------------------------------------------------------------
	// Register port
	// --------------------------------------------------------------
	wire [31:0] status = {18'h0, wr_r, act_r, pwr_r, busy, open_r};
	wire [31:0] rd_mux =
		(reg_addr == REG_MODE) ? {26'h0, mode_r} :
		(reg_addr == REG_STATUS) ? status : 32'h0;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_r <= MODE_RST;
			reg_rdata <= '0;
		end
		else
		begin
			if (reg_wr && reg_addr == REG_MODE)
				mode_r <= reg_wdata[MODE_W-1:0];
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end
	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wr_restart_a: assert property (
		(c_wr && mask != '0) |=> (act_r && wr_r && beat_r == 9'h001))
		else $error("write did not restart burst");
	rd_cut_wr_a: assert property (
		(c_rd && act_r && wr_r) |=> (!wr_r && !arr_req.we))
		else $error("read did not cut write burst");
	bst_stop_a: assert property (
		(c_bst && act_r) |=> (!act_r && !arr_req.we && !arr_req.re))
		else $error("burst stop ignored");
	bst_hiz_a: assert property (
		(c_bst && act_r && !wr_r && cl == 2'h3) |-> ##3 !dq_oe)
		else $error("output still driven after stop");
	seq_order_a: assert property (
		(go && !nb && !ilv && act_r && $past(go)) |->
		(((cur_col - $past(cur_col)) & mask) == 1 &&
		(cur_col & ~mask) == (cur_start & ~mask)))
		else $error("sequential column step wrong");
	ilv_order_a: assert property (
		(go && !nb && ilv && !full) |=>
		((arr_req.col ^ $past(start_r)) == $past(beat_r)))
		else $error("interleaved column wrong");
	rd_ap_a: assert property (
		rd_ap_go |=> !open_r[$past(cur_bank)])
		else $error("read auto-precharge missing");
	wr_ap_a: assert property (
		(last && cur_wr && cur_ap) |-> ##1 wr_ap_go ##1
		!open_r[$past(wap_bank_r)])
		else $error("write auto-precharge late");
	pre_all_a: assert property (
		(c_pre && addr[AP_BIT]) |=> (open_r == '0 && busy != '0))
		else $error("precharge all failed");
	self_entry_a: assert property (
		c_self |=> (pwr_r == ST_SELF))
		else $error("self refresh not entered");
	srex_wait_a: assert property (
		(pwr_r == ST_SELF && cke) |=>
		(pwr_r == ST_EXIT && !arr_req.re)[*8] ##1 (pwr_r == ST_RUN))
		else $error("self refresh exit wait wrong");
	pdown_a: assert property (
		(run && !cke && !c_self && !act_r && wap_cnt_r == '0) |=>
		(pwr_r == ST_PDOWN))
		else $error("power-down not entered");
	nop_keep_a: assert property (
		(act_r && !last && (cmd.cs_n || code == CMD_NOP)) |=> act_r)
		else $error("no-operation ended burst");
	wr_int_c: cover property (act_r && wr_r && c_wr);
	rd_ap_c: cover property (rd_ap_go);
	self_c: cover property (pwr_r == ST_EXIT ##1 pwr_r == ST_RUN);
	bst_c: cover property (c_bst && act_r && full);
endmodule : sdram_cmd_core

// ---- tb/array_model.sv ----
// Behavioural cell array behind the command core
`timescale 1ns/1ps
module array_model (
	input logic clk,
	input sdram_pkg::arr_req_t req,
	output logic [sdram_pkg::DATA_W-1:0] rdata
);
	import sdram_pkg::*;
	logic [DATA_W-1:0] mem [1<<(BANK_W+COL_W)];
	logic junk_r = 1'b0;
	wire [BANK_W+COL_W-1:0] idx = {req.bank, req.col};
	// Row ignored: bench keeps one row open per bank
	always @(posedge clk)
	begin
		junk_r <= ~junk_r;
		if (req.we)
			mem[idx] <= req.wdata;
	end
	// Idle read path toggles so stale data never looks valid
	assign rdata = req.re ? mem[idx] : {8{junk_r, ~junk_r}};
endmodule : array_model

// ---- tb/testbench.sv ----
// Self-checking bench of the SDRAM command core
`timescale 1ns/1ps
module testbench;
	import sdram_pkg::*;
	logic clk, resetn, cke, dqm, reg_wr, reg_rd, dq_oe;
	cmd_t cmd;
	logic [1:0] ba;
	logic [11:0] addr;
	logic [15:0] dq_i, dq_o, arr_rdata;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	arr_req_t arr_req;
	int fails, tests_run;
	logic [5:0] mode_tbl [7] = '{6'h30, 6'h31, 6'h32, 6'h33, 6'h39,
		6'h3a, 6'h2b};
	logic [8:0] col_tbl [7] = '{9'h003, 9'h011, 9'h026, 9'h0f5, 9'h043,
		9'h05e, 9'h1fd};

	sdram_cmd_core dut (.clk(clk), .resetn(resetn), .cke(cke), .cmd(cmd),
		.ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i), .dq_o(dq_o),
		.dq_oe(dq_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.arr_req(arr_req), .arr_rdata(arr_rdata));
	array_model model (.clk(clk), .req(arr_req), .rdata(arr_rdata));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task issue(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		cmd <= cmd_t'(c);
		ba <= b;
		addr <= a;
		dq_i <= d;
	endtask : issue

	task idle(input int n);
		repeat (n) issue(CMD_NOP, 2'h0, 12'h000, 16'h0000);
	endtask : idle

	task rreg(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rreg

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wreg

	function automatic logic [8:0] ecol(input logic [8:0] s, input int k,
		input logic [8:0] m, input logic il);
		ecol = il ? s ^ 9'(k) : (s & ~m) | ((s + 9'(k)) & m);
	endfunction : ecol

	// Filler beats are deselects; dq_i carries each beat's write data, ba and addr repeat the write's
	task wr_burst(input logic [8:0] s, input int bl, input logic il,
		input logic ap);
		int n;
		n = 1 << bl;
		for (int k = 0; k <= n; k++)
		begin
			issue(k == 0 ? CMD_WR : 4'h8, 2'h0, {1'b0, ap, 1'b0, s},
				{4'(k), 3'h0, s});
			#1;
			if (k > 0)
			begin
				chk("wr_col", arr_req.col, ecol(s, k - 1, 9'(n - 1), il));
				chk("wr_data", arr_req.wdata, {4'(k - 1), 3'h0, s});
				chk("wr_we", arr_req.we, 1'b1);
				chk("wr_row", {arr_req.bank, arr_req.row}, 14'h0005);
			end
		end
		idle(1);
		#1 chk("wr_end", arr_req.we, 1'b0);
	endtask : wr_burst

	task rd_burst(input logic [8:0] s, input int bl, input int cl,
		input logic ap);
		int n;
		n = 1 << bl;
		issue(CMD_RD, 2'h0, {1'b0, ap, 1'b0, s}, 16'h0000);
		idle(1);
		repeat (cl - 1) @(posedge clk);
		for (int k = 0; k < n; k++)
		begin
			@(negedge clk);
			chk("rd_oe", dq_oe, 1'b1);
			chk("rd_data", dq_o, {4'(k), 3'h0, s});
			@(posedge clk);
		end
		@(negedge clk);
		chk("rd_idle", dq_oe, 1'b0);
	endtask : rd_burst

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		resetn = 1'b0;
		cke = 1'b1;
		dqm = 1'b0;
		cmd = cmd_t'(CMD_NOP);
		ba = 2'h0;
		addr = 12'h000;
		dq_i = 16'h0000;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fails = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		chk("rst_req", {arr_req.we, arr_req.re, dq_oe}, 3'h0);
		resetn <= 1'b1;
		rreg(REG_MODE);
		chk("mode_rst", v, 32'h33);
		wreg(8'h08, 32'h3f);
		rreg(REG_MODE);
		chk("mode_keep", v, 32'h33);
		rreg(8'h08);
		chk("unmapped", v, 32'h0);
		rreg(REG_STATUS);
		chk("pwr_rst", v[11:8], 4'h1);
		@(posedge clk);
		#1 chk("rdata_drop", reg_rdata, 32'h0);
		issue(CMD_ACT, 2'h0, 12'h005, 16'h0000);
		idle(2);
		for (int i = 0; i < 7; i++)
		begin
			wreg(REG_MODE, 32'(mode_tbl[i]));
			wr_burst(col_tbl[i], mode_tbl[i][2:0], mode_tbl[i][3], 1'b0);
			rd_burst(col_tbl[i], mode_tbl[i][2:0], mode_tbl[i][5:4], 1'b0);
		end
		// Write cut by write, then by read
		wreg(REG_MODE, 32'h32);
		issue(CMD_WR, 2'h0, 12'h010, 16'h1111);
		issue(4'h8, 2'h0, 12'h000, 16'h2222);
		wr_burst(9'h020, 2, 1'b0, 1'b0);
		issue(CMD_WR, 2'h0, 12'h030, 16'h3333);
		issue(CMD_RD, 2'h0, 12'h030, 16'h0000);
		idle(1);
		#1 chk("wr_cut", {arr_req.we, arr_req.re}, 2'h1);
		idle(7);
		// Burst stop in full page, read then write
		wreg(REG_MODE, 32'h37);
		issue(CMD_RD, 2'h0, 12'h000, 16'h0000);
		idle(2);
		issue(CMD_BST, 2'h0, 12'h000, 16'h0000);
		idle(1);
		@(negedge clk);
		@(negedge clk);
		chk("bst_last", dq_oe, 1'b1);
		@(negedge clk);
		chk("bst_hiz", dq_oe, 1'b0);
		issue(CMD_WR, 2'h0, 12'h000, 16'h4444);
		issue(4'h8, 2'h0, 12'h000, 16'h5555);
		issue(CMD_BST, 2'h0, 12'h000, 16'h6666);
		idle(1);
		#1 chk("bst_wr", arr_req.we, 1'b0);
		idle(3);
		// Read cut by write, old read data masked
		wreg(REG_MODE, 32'h22);
		issue(CMD_RD, 2'h0, 12'h050, 16'h0000);
		dqm <= 1'b1;
		idle(1);
		issue(CMD_WR, 2'h0, 12'h050, 16'h7777);
		dqm <= 1'b0;
		@(negedge clk);
		chk("rd_mask0", dq_oe, 1'b0);
		idle(1);
		@(negedge clk);
		chk("rd_mask1", dq_oe, 1'b0);
		chk("wr_unmask", arr_req.we, 1'b1);
		idle(5);
		// Auto-precharge on write and read
		wreg(REG_MODE, 32'h32);
		wr_burst(9'h040, 2, 1'b0, 1'b1);
		idle(3);
		rreg(REG_STATUS);
		chk("ap_wr", v[0], 1'b0);
		issue(CMD_RD, 2'h0, 12'h040, 16'h0000);
		idle(1);
		#1 chk("closed_rd", arr_req.re, 1'b0);
		idle(3);
		issue(CMD_ACT, 2'h0, 12'h005, 16'h0000);
		idle(2);
		rd_burst(9'h040, 2, 3, 1'b1);
		rreg(REG_STATUS);
		chk("ap_rd", v[0], 1'b0);
		// Precharge one bank, then all
		idle(3);
		issue(CMD_ACT, 2'h0, 12'h005, 16'h0000);
		issue(CMD_ACT, 2'h1, 12'h005, 16'h0000);
		issue(CMD_ACT, 2'h2, 12'h005, 16'h0000);
		idle(1);
		rreg(REG_STATUS);
		chk("open3", v[3:0], 4'h7);
		issue(CMD_PRE, 2'h1, 12'h000, 16'h0000);
		rreg(REG_STATUS);
		chk("pre_one", v[3:0], 4'h5);
		issue(CMD_PRE, 2'h0, 12'h400, 16'h0000);
		rreg(REG_STATUS);
		chk("pre_all", v[3:0], 4'h0);
		// Power-down, then self refresh
		idle(3);
		@(posedge clk);
		cke <= 1'b0;
		idle(2);
		rreg(REG_STATUS);
		chk("pdown", v[11:8], 4'h2);
		@(posedge clk);
		cke <= 1'b1;
		idle(1);
		rreg(REG_STATUS);
		chk("pd_exit", v[11:8], 4'h1);
		@(posedge clk);
		cke <= 1'b0;
		cmd <= cmd_t'(CMD_REF);
		idle(1);
		rreg(REG_STATUS);
		chk("self", v[11:8], 4'h4);
		issue(CMD_ACT, 2'h3, 12'h005, 16'h0000);
		@(posedge clk);
		cke <= 1'b1;
		cmd <= cmd_t'(CMD_NOP);
		rreg(REG_STATUS);
		chk("self_exit", v[11:8], 4'h8);
		idle(10);
		rreg(REG_STATUS);
		chk("self_done", {v[11:8], v[3]}, 5'h02);
		// Reset in mid-run restores mode 0x33 and clears banks
		issue(CMD_ACT, 2'h1, 12'h005, 16'h0000);
		idle(2);
		resetn <= 1'b0;
		idle(2);
		chk("rst_mid", {arr_req.we, arr_req.re, dq_oe}, 3'h0);
		resetn <= 1'b1;
		rreg(REG_MODE);
		chk("mode_rst2", v, 32'h33);
		rreg(REG_STATUS);
		chk("state_rst", {v[11:8], v[3:0]}, 8'h10);
		wrap_up;
	end

	initial
	begin
		#200000;
		fails++;
		wrap_up;
	end
endmodule : testbench
